// *** drr_router.sv ***
// Top of the DMA request router channel configuration and input selection.
// Behaviour
// - Generator trigger picks external, event or timer
// - Sync selector uses the same code map
// - Sync source at 28:24, reserved bits zero
// - Twelve channel registers, four bytes apart
// - Register block decoded at fixed base
// - Channel registers reset to zero
// - Forward count is field value plus one
// - Two-bit edge select, active with sync enable
// - Bit nine enables event output
// - Seven-bit selector routes one request input
// - Bit eight enables the overrun interrupt
// - Sync during open window sets overrun flag
`timescale 1ns/1ps
`include "drr_consts.svh"
module drr_router
   import drr_pkg::*;
#(
   parameter int NUM_CH = 12,
   parameter int NUM_GEN = 4
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [15:0] external_interrupt_line_i,
   input wire logic timer20_channel0_output_i,
   input wire logic [127:5] periph_req_i,
   output logic [NUM_CH-1:0] dma_req_o,
   output logic [NUM_CH-1:0] evt_o,
   output logic irq_o
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [31:0] cfg_reg [NUM_CH];
   logic [31:0] gen_reg [NUM_GEN];
   logic [NUM_CH-1:0] flag_reg;
   logic [NUM_CH-1:0] flag_next;
   logic [NUM_CH-1:0] req_reg;
   logic [NUM_CH-1:0] evt_reg;
   logic [31:0] dat_reg;
   logic ack_reg;
   logic irq_reg;
   logic [15:0] ext_s1_reg;
   logic [15:0] ext_s2_reg;
   logic tmr_s1_reg;
   logic tmr_s2_reg;

   assign dat_o = dat_reg;
   assign ack_o = ack_reg;
   assign dma_req_o = req_reg;
   assign evt_o = evt_reg;
   assign irq_o = irq_reg;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_s1_reg <= 16'h0000;
         ext_s2_reg <= 16'h0000;
         tmr_s1_reg <= 1'b0;
         tmr_s2_reg <= 1'b0;
      end else begin
         ext_s1_reg <= external_interrupt_line_i;
         ext_s2_reg <= ext_s1_reg;
         tmr_s1_reg <= timer20_channel0_output_i;
         tmr_s2_reg <= tmr_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // Wishbone decode
   // ------------------------------------------------------------
   logic [31:0] rel;
   logic acc;
   logic wr;
   logic cfg_hit;
   logic gen_hit;
   logic [3:0] cfg_idx;
   logic [1:0] gen_idx;
   logic [31:0] rd;

   // offsets relative to the block base
   assign rel = adr_i - `DRR_BASE;
   assign acc = cyc_i & stb_i & ~ack_reg;
   assign wr = acc & we_i & (sel_i == 4'hF);
   // channel register at index times four
   assign cfg_idx = rel[5:2];
   assign cfg_hit = (rel[31:6] == 26'h0) && (rel[1:0] == 2'h0) && (32'(cfg_idx) < NUM_CH);
   assign gen_idx = rel[3:2];
   assign gen_hit = ({rel[31:4], 4'h0} == `DRR_GEN_OFF) && (rel[1:0] == 2'h0)
                    && (32'(gen_idx) < NUM_GEN);

   always_comb begin
      rd = 32'h0000_0000;
      if (cfg_hit) rd = cfg_reg[cfg_idx];
      else if (gen_hit) rd = gen_reg[gen_idx];
      else if (rel == `DRR_FLAG_OFF) rd = 32'(flag_reg);
   end

   // Every access is answered one cycle later; unmapped reads return zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= acc;
         if (acc && !we_i) dat_reg <= rd;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   // Reserved bits are masked on write so they always read back as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_CH; i++) cfg_reg[i] <= `DRR_CFG_RST;
      end else if (wr && cfg_hit) begin
         cfg_reg[cfg_idx] <= dat_i & `DRR_CFG_WMASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_GEN; i++) gen_reg[i] <= `DRR_CFG_RST;
      end else if (wr && gen_hit) begin
         gen_reg[gen_idx] <= dat_i & `DRR_GEN_WMASK;
      end
   end

   // ------------------------------------------------------------
   // Request generators
   // ------------------------------------------------------------
   logic [NUM_GEN-1:0] gen_req;
   logic [NUM_GEN-1:0] gen_hit_v;

   for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
      drr_src_sel u_trig (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ext_i(ext_s2_reg),
         .evt_i(evt_reg[3:0]),
         .tmr_i(tmr_s2_reg),
         .sel_i(gen_reg[g][4:0]),
         .edge_i(gen_reg[g][`DRR_EDGE_LSB+1:`DRR_EDGE_LSB]),
         .hit_o(gen_hit_v[g])
      );
      assign gen_req[g] = gen_hit_v[g] & gen_reg[g][`DRR_GEN_EN_BIT];
   end

   // ------------------------------------------------------------
   // Multiplexer channels
   // ------------------------------------------------------------
   logic [127:0] all_req;
   logic [NUM_CH-1:0] fwd;
   logic [NUM_CH-1:0] evt;
   logic [NUM_CH-1:0] ovr;
   logic [NUM_CH-1:0] sync_hit;
   logic [NUM_CH-1:0] mux_req;

   // Code zero selects no request; codes one to four are the generators.
   assign all_req = {periph_req_i, gen_req, 1'b0};

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      assign mux_req[c] = all_req[cfg_reg[c][6:0]];
      drr_src_sel u_sync (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ext_i(ext_s2_reg),
         .evt_i(evt_reg[3:0]),
         .tmr_i(tmr_s2_reg),
         .sel_i(cfg_reg[c][`DRR_SRC_LSB+4:`DRR_SRC_LSB]),
         .edge_i(cfg_reg[c][`DRR_EDGE_LSB+1:`DRR_EDGE_LSB]),
         .hit_o(sync_hit[c])
      );
      // count is read live, so software holds it stable
      drr_chan u_chan (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .sync_en_i(cfg_reg[c][`DRR_SEN_BIT]),
         .evg_en_i(cfg_reg[c][`DRR_EVG_BIT]),
         .cnt_i(cfg_reg[c][`DRR_CNT_LSB+4:`DRR_CNT_LSB]),
         .req_i(mux_req[c]),
         .sync_i(sync_hit[c]),
         .fwd_o(fwd[c]),
         .evt_o(evt[c]),
         .ovr_o(ovr[c])
      );
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_reg <= '0;
         evt_reg <= '0;
      end else begin
         req_reg <= fwd;
         evt_reg <= evt;
      end
   end

   // ------------------------------------------------------------
   // Overrun flags and interrupt
   // ------------------------------------------------------------
   logic [NUM_CH-1:0] clr;
   logic [NUM_CH-1:0] oie;

   assign clr = (wr && (rel == `DRR_CLR_OFF)) ? dat_i[NUM_CH-1:0] : '0;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) oie[i] = cfg_reg[i][`DRR_OIE_BIT];
      // A new overrun in the clearing cycle wins over the clear.
      flag_next = (flag_reg & ~clr) | ovr;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) flag_reg <= '0;
      else flag_reg <= flag_next;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) irq_reg <= 1'b0;
      else irq_reg <= |(flag_next & oie);
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_ack;
      ack_o ##1 !ack_o;
   endsequence

   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> s_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer not a one-cycle ack");

   property p_reset;
      @(posedge clk_i)
      rst_i |=> (cfg_reg[0] == 32'h0000_0000 && flag_reg == '0 && !irq_o);
   endproperty
   a_reset: assert property (p_reset)
      else $error("channel state not cleared by reset");

   property p_reserved;
      @(posedge clk_i) disable iff (rst_i)
      (cfg_reg[NUM_CH-1] & ~`DRR_CFG_WMASK) == 32'h0000_0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved configuration bit set");

   property p_wr_ch3;
      @(posedge clk_i) disable iff (rst_i)
      (wr && adr_i == `DRR_BASE + 3 * `DRR_CFG_STRIDE)
      |=> cfg_reg[3] == ($past(dat_i) & `DRR_CFG_WMASK);
   endproperty
   a_wr_ch3: assert property (p_wr_ch3)
      else $error("channel three word not written");

   property p_flag;
      @(posedge clk_i) disable iff (rst_i)
      ovr[2] |=> (flag_reg[2] && (irq_o || !$past(oie[2])));
   endproperty
   a_flag: assert property (p_flag)
      else $error("overrun flag or interrupt wrong");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
      (flag_reg[2] && oie[2]) |=> irq_o || $past(clr[2]);
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled overrun without interrupt");

   property p_fwd_out;
      @(posedge clk_i) disable iff (rst_i)
      fwd[2] |=> dma_req_o[2];
   endproperty
   a_fwd_out: assert property (p_fwd_out)
      else $error("forwarded request not driven out");
endmodule // drr_router

// *** drr_consts.svh ***
// Register map, field positions and source codes of the DMA request router.
`ifndef DRR_CONSTS_SVH
`define DRR_CONSTS_SVH
`define DRR_BASE 32'h4002_0800
`define DRR_CFG_STRIDE 32'h0000_0004
`define DRR_FLAG_OFF 32'h0000_0080
`define DRR_CLR_OFF 32'h0000_0084
`define DRR_GEN_OFF 32'h0000_0100
`define DRR_CFG_RST 32'h0000_0000
`define DRR_CFG_WMASK 32'h1FFF_037F
`define DRR_GEN_WMASK 32'h0007_001F
`define DRR_SRC_LSB 24
`define DRR_CNT_LSB 19
`define DRR_EDGE_LSB 17
`define DRR_SEN_BIT 16
`define DRR_EVG_BIT 9
`define DRR_OIE_BIT 8
`define DRR_GEN_EN_BIT 16
`define DRR_CODE_EXT_MAX 5'h0F
`define DRR_CODE_EVT_LO 5'h10
`define DRR_CODE_EVT_HI 5'h13
`define DRR_CODE_TMR 5'h16
`endif

// *** drr_pkg.sv ***
// Types shared by the DMA request router modules.
package drr_pkg;
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } drr_edge_t;
   typedef enum logic [1:0] {
      ST_WAIT = 2'b01,
      ST_FWD = 2'b10
   } drr_state_t;
endpackage

// *** drr_src_sel.sv ***
// Source selection and edge detection for one trigger or sync input.
`timescale 1ns/1ps
`include "drr_consts.svh"
module drr_src_sel
   import drr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [15:0] ext_i,
   input wire logic [3:0] evt_i,
   input wire logic tmr_i,
   input wire logic [4:0] sel_i,
   input wire logic [1:0] edge_i,
   output logic hit_o
);
   logic level;
   logic level_reg;

   function automatic logic pick(input logic [4:0] s, input logic [15:0] e,
                                 input logic [3:0] v, input logic t);
      logic [4:0] k;
      k = s - `DRR_CODE_EVT_LO;
      if (s <= `DRR_CODE_EXT_MAX) pick = e[s[3:0]];
      else if (s <= `DRR_CODE_EVT_HI) pick = v[k[1:0]];
      else if (s == `DRR_CODE_TMR) pick = t;
      else pick = 1'b0;
   endfunction

   assign level = pick(sel_i, ext_i, evt_i, tmr_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) level_reg <= 1'b0;
      else level_reg <= level;
   end

   always_comb begin
      unique case (drr_edge_t'(edge_i))
         EDGE_NONE: hit_o = 1'b0;
         EDGE_RISE: hit_o = level & ~level_reg;
         EDGE_FALL: hit_o = ~level & level_reg;
         EDGE_BOTH: hit_o = level ^ level_reg;
      endcase
   end

   property p_reserved_code;
      @(posedge clk_i) disable iff (rst_i)
      (sel_i > `DRR_CODE_EVT_HI && sel_i != `DRR_CODE_TMR) |-> !level;
   endproperty
   a_reserved_code: assert property (p_reserved_code)
      else $error("reserved source code is not inactive");
endmodule // drr_src_sel

// *** drr_chan.sv ***
// Forward counter, sync gating and event output of one multiplexer channel.
`timescale 1ns/1ps
`include "drr_consts.svh"
module drr_chan
   import drr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sync_en_i,
   input wire logic evg_en_i,
   input wire logic [4:0] cnt_i,
   input wire logic req_i,
   input wire logic sync_i,
   output logic fwd_o,
   output logic evt_o,
   output logic ovr_o
);
   drr_state_t state_reg;
   logic [4:0] fwd_cnt_reg;
   logic last;

   // with sync enabled, requests pass only inside a sync window
   assign fwd_o = req_i & (~sync_en_i | (state_reg == ST_FWD));
   // count reaches field value plus one
   assign last = fwd_o & (fwd_cnt_reg == cnt_i);
   assign evt_o = last & evg_en_i;
   // sync while the window is still open
   assign ovr_o = sync_en_i & sync_i & (state_reg == ST_FWD);

   always_ff @(posedge clk_i) begin
      if (rst_i) fwd_cnt_reg <= 5'h00;
      else if (last || (sync_en_i && sync_i && state_reg == ST_WAIT)) fwd_cnt_reg <= 5'h00;
      else if (fwd_o) fwd_cnt_reg <= fwd_cnt_reg + 5'h01;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !sync_en_i) state_reg <= ST_WAIT;
      else begin
         unique case (state_reg)
            ST_WAIT: if (sync_i) state_reg <= ST_FWD;
            ST_FWD: if (last) state_reg <= ST_WAIT;
         endcase
      end
   end

   property p_blocked;
      @(posedge clk_i) disable iff (rst_i)
      (sync_en_i && state_reg == ST_WAIT) |-> !fwd_o;
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("request forwarded without a sync event");

   property p_evt;
      @(posedge clk_i) disable iff (rst_i)
      (fwd_o && fwd_cnt_reg == cnt_i) |-> (evt_o == evg_en_i) ##1 (fwd_cnt_reg == 5'h00);
   endproperty
   a_evt: assert property (p_evt)
      else $error("event not at the programmed count");

   property p_ovr;
      @(posedge clk_i) disable iff (rst_i)
      (sync_en_i && sync_i && state_reg == ST_FWD) |-> ovr_o;
   endproperty
   a_ovr: assert property (p_ovr)
      else $error("overrun missed");

   property p_free;
      @(posedge clk_i) disable iff (rst_i)
      (!sync_en_i && req_i) |-> fwd_o;
   endproperty
   a_free: assert property (p_free)
      else $error("request dropped with sync off");
endmodule // drr_chan

// *** drr_dma_model.sv ***
// Model of the DMA controller that takes the forwarded requests and events.
`timescale 1ns/1ps
module drr_dma_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [11:0] dma_req_i,
   input wire logic [11:0] evt_i,
   output int req_cnt_o [12],
   output int evt_cnt_o [12],
   output int lone_evt_o
);
   // -----------------------------------------------------------
   // Request and event tally
   // -----------------------------------------------------------
   // An event without a request beside it is counted as a fault.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lone_evt_o <= 0;
         for (int i = 0; i < 12; i++) begin
            req_cnt_o[i] <= 0;
            evt_cnt_o[i] <= 0;
         end
      end else begin
         for (int i = 0; i < 12; i++) begin
            if (dma_req_i[i] === 1'b1) begin
               req_cnt_o[i] <= req_cnt_o[i] + 1;
            end
            if (evt_i[i] === 1'b1) begin
               evt_cnt_o[i] <= evt_cnt_o[i] + 1;
            end
            if (evt_i[i] === 1'b1 && dma_req_i[i] !== 1'b1) begin
               lone_evt_o <= lone_evt_o + 1;
            end
         end
      end
   end
endmodule // drr_dma_model

// *** test_drr_router.sv ***
// Self-checking testbench of the DMA request router.
`timescale 1ns/1ps
`include "drr_consts.svh"
module test_drr_router
   import drr_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic we_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic tmr = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic [15:0] ext = 16'h0;
   logic [127:5] preq = '0;
   logic [31:0] dat_o, rd, w;
   logic [31:0] lfsr_reg = 32'h0000_0050;
   logic ack_o, irq_o;
   logic [11:0] dma_req, evt;
   int req_cnt [12];
   int evt_cnt [12];
   int lone, mismatches = 0, num_checks = 0;
   int exp_req [12] = '{default: 0};
   int exp_evt [12] = '{default: 0};

   drr_router DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
      .ack_o(ack_o), .external_interrupt_line_i(ext), .timer20_channel0_output_i(tmr),
      .periph_req_i(preq), .dma_req_o(dma_req), .evt_o(evt), .irq_o(irq_o));
   drr_dma_model DMA_M (.clk_i(clk_i), .rst_i(rst_i), .dma_req_i(dma_req), .evt_i(evt),
      .req_cnt_o(req_cnt), .evt_cnt_o(evt_cnt), .lone_evt_o(lone));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // -----------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic wr, input logic [31:0] off, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= wr;
      adr_i <= `DRR_BASE + off;
      dat_i <= d;
      sel_i <= s;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic wrr(input logic [31:0] off, input logic [31:0] d);
      wb(1'b1, off, d, 4'hF);
   endtask

   task automatic rdc(input logic [31:0] off, input logic [31:0] exp);
      wb(1'b0, off, 32'h0, 4'hF);
      check("register", rd, exp);
   endtask

   // One-cycle request pulses, a free cycle between them.
   task automatic pulse(input int code, input int k);
      repeat (k) begin
         @(posedge clk_i);
         preq[code] <= 1'b1;
         @(posedge clk_i);
         preq[code] <= 1'b0;
      end
      repeat (3) @(posedge clk_i);
   endtask

   // Pins cross two synchroniser stages, so let them settle.
   task automatic pins(input logic [15:0] v, input logic t);
      @(posedge clk_i);
      ext <= v;
      tmr <= t;
      repeat (6) @(posedge clk_i);
   endtask

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      lfsr_next = v[0] ? (v >> 1) ^ 32'h8020_0003 : v >> 1;
   endfunction

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk_i);
      mismatches++;
      end_sim();
   end

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int c = 0; c < 12; c++) begin
         rdc(4 * c, 32'h0); // reset value
      end
      for (int c = 0; c < 12; c++) begin
         lfsr_reg = lfsr_next(lfsr_reg);
         wrr(4 * c, lfsr_reg);
         rdc(4 * c, lfsr_reg & `DRR_CFG_WMASK); // field map
         wrr(4 * c, lfsr_reg & 32'hFFFE_FDFF);
         wrr(4 * c, 32'h0);
      end
      wrr(32'h84, 32'h0000_0FFF);
      rdc(32'h30, 32'h0); // past last channel
      rdc(32'h90, 32'h0); // unmapped offset
      wb(1'b1, 32'h0, 32'h0000_0005, 4'h3);
      rdc(32'h0, 32'h0); // partial write dropped
      // Generators: ext line 5, event output 0, timer pin.
      wrr(32'h100, 32'h0003_0005);
      wrr(32'h104, 32'h0003_0010);
      wrr(32'h108, 32'h0003_0016);
      wrr(32'h10, 32'h1);
      wrr(32'h14, 32'h2);
      wrr(32'h18, 32'h3);
      pins(16'h0020, 1'b1);
      pins(16'h0, 1'b0);
      exp_req[4] = 1;
      exp_req[6] = 1;
      wrr(32'h100, 32'h0);
      // Free running: count field 2 gives three per event.
      wrr(32'h0, 32'h0010_0205);
      pulse(5, 6);
      exp_req[0] = 6;
      exp_evt[0] = 2;
      exp_req[5] = 2;
      // Synchronised channel 2 on ext line 3, rising edge, two per window.
      wrr(32'h08, 32'h030B_0306);
      pulse(6, 2);
      pins(16'h0008, 1'b0);
      pulse(6, 3);
      pins(16'h0, 1'b0);
      pulse(6, 1);
      pins(16'h0008, 1'b0);
      pulse(6, 1);
      pins(16'h0, 1'b0);
      pins(16'h0008, 1'b0);
      exp_req[2] = 3;
      exp_evt[2] = 1;
      rdc(32'h80, 32'h0000_0004); // overrun flag
      check("irq", {31'h0, irq_o}, 32'h1); // enabled interrupt
      wrr(32'h08, 32'h030B_0206);
      // The interrupt register follows the enable bit one edge after the write.
      @(posedge clk_i);
      check("irq", {31'h0, irq_o}, 32'h0); // masked interrupt
      wrr(32'h84, 32'h0000_0004);
      rdc(32'h80, 32'h0); // flag cleared
      // Every edge mode on channel 7, ext line 7, one per window.
      for (int e = 0; e < 4; e++) begin
         w = 32'h0700_0008 | (32'(e) << 17);
         wrr(32'h1C, w);
         wrr(32'h1C, w | 32'h0001_0000);
         pins(16'h0080, 1'b0);
         pulse(8, 1);
         pins(16'h0, 1'b0);
         pulse(8, 1);
         exp_req[7] += e % 2 + e / 2;
      end
      // Reserved sync codes never open a window.
      for (int c = 20; c < 32; c++) begin
         if (c != 22) begin
            wrr(32'h0C, (32'(c) << 24) | 32'h0007_0007);
            pins(16'hFFFF, 1'b0);
            pins(16'h0, 1'b0);
            pulse(7, 1);
         end
      end
      for (int c = 0; c < 12; c++) begin
         check("requests", 32'(req_cnt[c]), 32'(exp_req[c]));
         check("events", 32'(evt_cnt[c]), 32'(exp_evt[c])); // event count
      end
      check("lone events", 32'(lone), 32'h0); // event with last request
      end_sim();
   end
endmodule // test_drr_router
